// >>> fwc_array_model.sv
/*
  Behavioural flash and EEPROM arrays facing the nonvolatile write control.
  Assumes the bench hands it the EEPROM address it last loaded.
*/
`timescale 1ns/100ps

module fwc_array_model (
  // Block side
  input wire logic core_clk,
  input wire fwc_pkg::fwc_cmd_t nvm_cmd,
  input wire logic [511:0] hold_data,
  input wire logic [21:0] table_pointer,
  input wire logic ee_rd_strobe,
  output logic [7:0] flash_rd_data,
  output logic [7:0] ee_rd_data,
  // Bench side
  input wire logic [9:0] ee_addr
);
  import fwc_pkg::*;

  logic [7:0] flash_mem [0:255];
  logic [7:0] ee_mem [0:1023];
  logic [7:0] ee_byte;

  // -----------------------------------------------------------
  // Read paths
  // -----------------------------------------------------------
  // Outside a read cycle the bus shows the inverse, so a late sample fails.
  assign ee_byte = ee_mem[ee_addr];
  assign ee_rd_data = ee_rd_strobe ? ee_byte : ~ee_byte;
  assign flash_rd_data = flash_mem[table_pointer[7:0]];

  // Both arrays start erased.
  initial
  begin
    foreach (flash_mem[i]) flash_mem[i] = 8'hFF;
    foreach (ee_mem[i]) ee_mem[i] = 8'hFF;
  end

  // -----------------------------------------------------------
  // Programming
  // -----------------------------------------------------------
  // Flash programming only clears bits, so an FF holding byte leaves the cell alone.
  always @(posedge core_clk)
    if (nvm_cmd.start)
      case (nvm_cmd.kind)
        FWC_OP_EE_WRITE: ee_mem[nvm_cmd.ee_addr] <= nvm_cmd.ee_data;
        FWC_OP_FLASH_WRITE: for (int i = 0; i < 64; i++)
          flash_mem[{nvm_cmd.block[1:0], i[5:0]}] <=
            flash_mem[{nvm_cmd.block[1:0], i[5:0]}] & hold_data[8*i +: 8];
        FWC_OP_FLASH_ERASE: for (int i = 0; i < 64; i++)
          flash_mem[{nvm_cmd.block[1:0], i[5:0]}] <= 8'hFF;
        default: ;
      endcase
endmodule // fwc_array_model

// >>> fwc_cfg.svh
/*
  Constants for the nonvolatile write control block: register indices,
  control bit positions, reset values and programming timer figures.
  Assumes it is included once per compile unit by its bare name.
*/
// Functional notes
// - Flash is programmed only as a whole 64-byte block, never single bytes.
// - Sixty-four byte holding registers, each loaded from the table latch by a table write.
// - Write-start begins a long write, stalling the core unless EEPROM, ended by the programming timer or a reset.
// - Holding registers return to FFh on reset and after every write.
// - Unlock needs 55h then 0AAh written before write-start is honoured.
// - A write cut short by pin or watchdog reset leaves the abort flag set.
// - EEPROM byte write erases then stores, timed by the on-chip timer.
// - EEPROM address is 10 bits; high register keeps only its low two bits.
// - Config select picks config space; otherwise program select picks flash or EEPROM.
// - Write permit clears at power-up; writes happen only while it is set.
// - Abort flag sets when permit is set, clears when the timed write completes.
// - Software can only set write-start; hardware clears it on completion.
// - Completion sets the done flag, bit 6 of flag register 4; software clears.
// - Read-start is set-only, self-clearing, and refused while program space is selected.
// - Unlock register stores nothing and always reads zero.
// - Row-erase enable makes write-start erase the pointed row, then clears itself.
// - Pointer upper register holds bit 21 config access and bits 20 to 16.
// - Pointer bits 5:0 pick the holding register; bits 21:6 pick the block.
// - Write-start needs permit set by an earlier access, not the same one.
// - During a write, control, EEPROM address and data writes are ignored.
// - EEPROM read data lands in the data register one cycle later and holds.
`ifndef FWC_CFG_SVH
`define FWC_CFG_SVH

// ----------------------------------------------------------------
// Register indices on the special function register port
// ----------------------------------------------------------------
`define FWC_IDX_TP_UPPER 4'h0
`define FWC_IDX_TP_HIGH 4'h1
`define FWC_IDX_TP_LOW 4'h2
`define FWC_IDX_TLATCH 4'h3
`define FWC_IDX_UNLOCK 4'h4
`define FWC_IDX_CTRL 4'h5
`define FWC_IDX_EE_DATA 4'h6
`define FWC_IDX_EE_ADDR_LO 4'h7
`define FWC_IDX_EE_ADDR_HI 4'h8
`define FWC_IDX_FLAG4 4'h9

// ----------------------------------------------------------------
// Control register bits and other fields
// ----------------------------------------------------------------
`define FWC_B_PSEL 7
`define FWC_B_CSEL 6
`define FWC_B_ERASE 4
`define FWC_B_ABORT 3
`define FWC_B_PERMIT 2
`define FWC_B_START 1
`define FWC_B_READ 0
`define FWC_B_DONE 6
`define FWC_UNLOCK_KEY1 8'h55
`define FWC_UNLOCK_KEY2 8'hAA
`define FWC_HOLD_RESET 8'hFF
`define FWC_BYTE_RESET 8'h00

// ----------------------------------------------------------------
// Programming timer
// ----------------------------------------------------------------
`define FWC_CLK_PERIOD_NS 4
`define FWC_PROG_TIME_NS 2000
`define FWC_PROG_CYCLES ((`FWC_PROG_TIME_NS + `FWC_CLK_PERIOD_NS - 1) / `FWC_CLK_PERIOD_NS)

`endif

// >>> fwc_pkg.sv
/*
  Types shared by the nonvolatile write control block and its users.
  Assumes the constants header is compiled alongside.
*/
package fwc_pkg;

  // ----------------------------------------------------------------
  // Register port request and array command carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fwc_sfr_req_t;

  typedef enum logic [1:0] {FWC_OP_EE_WRITE, FWC_OP_FLASH_WRITE, FWC_OP_FLASH_ERASE,
                            FWC_OP_CFG_WRITE} fwc_op_t;

  typedef struct packed {
    logic start;
    fwc_op_t kind;
    logic [15:0] block;
    logic [9:0] ee_addr;
    logic [7:0] ee_data;
  } fwc_cmd_t;

  typedef enum logic [1:0] {FWC_STEP_NONE, FWC_STEP_POST_INC, FWC_STEP_POST_DEC,
                            FWC_STEP_PRE_INC} fwc_step_t;

  typedef enum logic [1:0] {FWC_UL_IDLE, FWC_UL_KEY1, FWC_UL_ARMED} fwc_unlock_t;

endpackage

// >>> fwc_top.sv
/*
  Nonvolatile write control: table pointer, table latch, 64 holding
  registers, control and unlock registers, EEPROM address and data,
  programming timer and the command to the flash and EEPROM arrays.
  Assumes the arrays read combinationally on the presented address and
  that warm_reset is a synchronous request from the reset controller.
*/
`timescale 1ns/100ps
`include "fwc_cfg.svh"

module fwc_top (
  // Clock and resets
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic warm_reset,
  // Register port
  input wire fwc_pkg::fwc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Table instructions from the core
  input wire logic table_op_valid,
  input wire logic table_op_write,
  input wire fwc_pkg::fwc_step_t table_op_step,
  input wire logic [7:0] flash_rd_data,
  output logic [21:0] table_pointer,
  // Array side
  output fwc_pkg::fwc_cmd_t nvm_cmd,
  output logic [511:0] hold_data,
  input wire logic [7:0] ee_rd_data,
  output logic ee_rd_strobe,
  // Core and interrupt side
  output logic cpu_stall,
  output logic nvm_done_flag
);
  import fwc_pkg::*;

  localparam int PROG_CYC = `FWC_PROG_CYCLES;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [21:0] tp_q, tp_d;
  logic [7:0] tlatch_q, tlatch_d;
  logic psel_q, csel_q, erase_q, abort_q, permit_q, busy_q, rd_q;
  logic psel_d, csel_d, erase_d, abort_d, permit_d, busy_d, rd_d;
  logic [7:0] eeprom_byte_data_q, eeprom_byte_data_d;
  logic [9:0] ee_addr_q, ee_addr_d;
  logic done_q, done_d;
  logic [11:0] cnt_q, cnt_d;
  fwc_unlock_t ul_q, ul_d;
  fwc_cmd_t cmd_q, cmd_d;
  logic [7:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire sfr_any = sfr_req.wr | sfr_req.rd;
  wire [7:0] wd = sfr_req.wdata;
  wire we_tpu = sfr_req.wr && sfr_req.addr == `FWC_IDX_TP_UPPER;
  wire we_tph = sfr_req.wr && sfr_req.addr == `FWC_IDX_TP_HIGH;
  wire we_tpl = sfr_req.wr && sfr_req.addr == `FWC_IDX_TP_LOW;
  wire we_tlat = sfr_req.wr && sfr_req.addr == `FWC_IDX_TLATCH;
  wire we_unl = sfr_req.wr && sfr_req.addr == `FWC_IDX_UNLOCK;
  wire we_flag = sfr_req.wr && sfr_req.addr == `FWC_IDX_FLAG4;
  // Writes that would disturb a write in flight are dropped.
  wire we_ctrl = sfr_req.wr && sfr_req.addr == `FWC_IDX_CTRL && !busy_q;
  wire we_eed = sfr_req.wr && sfr_req.addr == `FWC_IDX_EE_DATA && !busy_q;
  wire we_eal = sfr_req.wr && sfr_req.addr == `FWC_IDX_EE_ADDR_LO && !busy_q;
  wire we_eah = sfr_req.wr && sfr_req.addr == `FWC_IDX_EE_ADDR_HI && !busy_q;

  // ----------------------------------------------------------------
  // Unlock sequence and write start
  // ----------------------------------------------------------------
  // The key register keeps no data; only the sequence state survives.
  always_comb
  begin
    ul_d = ul_q;
    if (we_unl && wd == `FWC_UNLOCK_KEY1)
      ul_d = FWC_UL_KEY1;
    else if (we_unl && wd == `FWC_UNLOCK_KEY2 && ul_q == FWC_UL_KEY1)
      ul_d = FWC_UL_ARMED;
    else if (sfr_any)
      ul_d = FWC_UL_IDLE;
  end

  // Permit is checked as stored before this access, so a single write
  // that sets permit and start together never launches anything.
  wire start_req = we_ctrl && wd[`FWC_B_START];
  wire start_ok = start_req && permit_q && ul_q == FWC_UL_ARMED;
  wire bad_start = start_req && !start_ok;
  wire done_w = busy_q && cnt_q == 12'h001;
  wire permit_rise = we_ctrl && wd[`FWC_B_PERMIT] && !permit_q;

  // Target chosen at the moment of start.
  fwc_op_t kind_w;
  assign kind_w = psel_d ? (csel_d ? FWC_OP_CFG_WRITE :
                  (erase_d ? FWC_OP_FLASH_ERASE : FWC_OP_FLASH_WRITE)) :
                  (csel_d ? FWC_OP_CFG_WRITE : FWC_OP_EE_WRITE);

  // ----------------------------------------------------------------
  // Control register next state
  // ----------------------------------------------------------------
  assign psel_d = we_ctrl ? wd[`FWC_B_PSEL] : psel_q;
  assign csel_d = we_ctrl ? wd[`FWC_B_CSEL] : csel_q;
  assign permit_d = we_ctrl ? wd[`FWC_B_PERMIT] : permit_q;
  // Erase enable drops by itself once the row erase has finished.
  assign erase_d = (done_w && cmd_q.kind == FWC_OP_FLASH_ERASE) ? 1'b0 :
                   (we_ctrl ? wd[`FWC_B_ERASE] : erase_q);
  // A hardware set beats the completion clear and any software write.
  assign abort_d = (permit_rise || bad_start) ? 1'b1 :
                   done_w ? 1'b0 :
                   (we_ctrl ? wd[`FWC_B_ABORT] : abort_q);
  // Start is set-only from software; the timer or a warm reset clears it.
  assign busy_d = start_ok ? 1'b1 : (done_w ? 1'b0 : busy_q);
  // Read start is refused while program or config space is selected.
  assign rd_d = we_ctrl && wd[`FWC_B_READ] && !psel_d && !csel_d;
  assign cnt_d = start_ok ? 12'(PROG_CYC) : (busy_q ? cnt_q - 12'h001 : cnt_q);
  assign done_d = done_w ? 1'b1 : (we_flag ? wd[`FWC_B_DONE] : done_q);

  // ----------------------------------------------------------------
  // Table pointer, table latch and EEPROM registers
  // ----------------------------------------------------------------
  wire step_pre = table_op_step == FWC_STEP_PRE_INC;
  wire [20:0] tp_inc = tp_q[20:0] + 21'h000001;
  wire [20:0] tp_dec = tp_q[20:0] - 21'h000001;
  wire [21:0] tp_eff = step_pre ? {tp_q[21], tp_inc} : tp_q;
  wire [20:0] tp_step = (table_op_step == FWC_STEP_POST_DEC) ? tp_dec :
                        (table_op_step == FWC_STEP_NONE) ? tp_q[20:0] : tp_inc;

  // Stepping touches only the low 21 bits; bit 21 stays as software set it.
  always_comb
  begin
    tp_d = tp_q;
    if (table_op_valid)
      tp_d = {tp_q[21], tp_step};
    else if (we_tpu)
      tp_d[21:16] = wd[5:0];
    else if (we_tph)
      tp_d[15:8] = wd;
    else if (we_tpl)
      tp_d[7:0] = wd;
  end

  assign tlatch_d = (table_op_valid && !table_op_write) ? flash_rd_data :
                    (we_tlat ? wd : tlatch_q);
  assign ee_addr_d = we_eal ? {ee_addr_q[9:8], wd} :
                     (we_eah ? {wd[1:0], ee_addr_q[7:0]} : ee_addr_q);
  assign eeprom_byte_data_d = rd_q ? ee_rd_data : (we_eed ? wd : eeprom_byte_data_q);

  // ----------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------
  // A pre-increment write lands on the stepped pointer, as the core expects.
  wire hold_we = table_op_valid && table_op_write;
  wire hold_clr = warm_reset || done_w;

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++)
    begin : g_hold
      logic [7:0] hold_q;
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
          hold_q <= `FWC_HOLD_RESET;
        else if (hold_clr)
          hold_q <= `FWC_HOLD_RESET;
        else if (hold_we && tp_eff[5:0] == 6'(gi))
          hold_q <= tlatch_q;
      end
      assign hold_data[gi*8 +: 8] = hold_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Array command
  // ----------------------------------------------------------------
  // One command always carries the whole block; no byte-wide flash op exists.
  always_comb
  begin
    cmd_d = cmd_q;
    cmd_d.start = start_ok;
    if (start_ok)
    begin
      cmd_d.kind = kind_w;
      cmd_d.block = tp_q[21:6];
      cmd_d.ee_addr = ee_addr_q;
      cmd_d.ee_data = eeprom_byte_data_q;
    end
  end

  // ----------------------------------------------------------------
  // Read-back mux
  // ----------------------------------------------------------------
  wire [7:0] ctrl_rd = {psel_q, csel_q, 1'b0, erase_q, abort_q, permit_q, busy_q, rd_q};
  always_comb
  begin
    case (sfr_req.addr)
      `FWC_IDX_TP_UPPER: rdata_d = {2'b00, tp_q[21:16]};
      `FWC_IDX_TP_HIGH: rdata_d = tp_q[15:8];
      `FWC_IDX_TP_LOW: rdata_d = tp_q[7:0];
      `FWC_IDX_TLATCH: rdata_d = tlatch_q;
      `FWC_IDX_UNLOCK: rdata_d = `FWC_BYTE_RESET;
      `FWC_IDX_CTRL: rdata_d = ctrl_rd;
      `FWC_IDX_EE_DATA: rdata_d = eeprom_byte_data_q;
      `FWC_IDX_EE_ADDR_LO: rdata_d = ee_addr_q[7:0];
      `FWC_IDX_EE_ADDR_HI: rdata_d = {6'h00, ee_addr_q[9:8]};
      `FWC_IDX_FLAG4: rdata_d = {1'b0, done_q, 6'h00};
      default: rdata_d = `FWC_BYTE_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  // Warm reset stops a write in flight and sets the abort flag, so
  // software can see that the block needs writing again.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {psel_q, csel_q, erase_q, abort_q} <= 4'h0;
      {permit_q, busy_q, rd_q, done_q} <= 4'h0;
      ul_q <= FWC_UL_IDLE;
      cnt_q <= 12'h000;
      cmd_q <= '0;
    end
    else if (warm_reset)
    begin
      // A write cut short here must stay visible as aborted.
      abort_q <= abort_q || busy_q;
      {erase_q, permit_q, busy_q, rd_q} <= 4'h0;
      ul_q <= FWC_UL_IDLE;
      cnt_q <= 12'h000;
      cmd_q.start <= 1'b0;
    end
    else
    begin
      {psel_q, csel_q, erase_q, abort_q} <= {psel_d, csel_d, erase_d, abort_d};
      {permit_q, busy_q, rd_q, done_q} <= {permit_d, busy_d, rd_d, done_d};
      ul_q <= ul_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
    end
  end

  // Data registers survive warm reset.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tp_q <= 22'h000000;
      tlatch_q <= `FWC_BYTE_RESET;
      eeprom_byte_data_q <= `FWC_BYTE_RESET;
      ee_addr_q <= 10'h000;
      rdata_q <= `FWC_BYTE_RESET;
    end
    else
    begin
      tp_q <= tp_d;
      tlatch_q <= tlatch_d;
      eeprom_byte_data_q <= eeprom_byte_data_d;
      ee_addr_q <= ee_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = rdata_q;
  assign table_pointer = tp_q;
  assign nvm_cmd = cmd_q;
  assign ee_rd_strobe = rd_q;
  // The core halts for flash writes, row erases and config writes; EEPROM runs in background.
  assign cpu_stall = busy_q && cmd_q.kind != FWC_OP_EE_WRITE;
  assign nvm_done_flag = done_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n || warm_reset);

  unlock_before_start_a: assert property ($rose(busy_q) |-> $past(ul_q) == FWC_UL_ARMED)
    else $error("write started without unlock");
  permit_earlier_a: assert property ($rose(busy_q) |-> $past(permit_q))
    else $error("write started without prior permit");
  timer_length_a: assert property ($rose(busy_q) |-> ##[PROG_CYC:PROG_CYC] $fell(busy_q))
    else $error("long write length wrong");
  stall_during_a: assert property (busy_q && cmd_q.kind == FWC_OP_FLASH_WRITE |-> cpu_stall)
    else $error("core not stalled in flash write");
  hold_reload_a: assert property ($fell(busy_q) |-> hold_data == {64{`FWC_HOLD_RESET}})
    else $error("holding registers not FFh after write");
  done_flag_a: assert property ($fell(busy_q) && !$past(warm_reset) |-> nvm_done_flag && !abort_q)
    else $error("completion flags wrong");
  start_clear_a: assert property ($fell(busy_q) && !$past(warm_reset) |-> $past(cnt_q) == 12'h001)
    else $error("start cleared before timer expiry");
  read_gate_a: assert property (rd_q |-> !psel_q && !csel_q)
    else $error("read started in program space");
  ee_read_a: assert property (rd_q |=> eeprom_byte_data_q == $past(ee_rd_data))
    else $error("read data not captured");
  addr_frozen_a: assert property (busy_q && $past(busy_q) |-> $stable(ee_addr_q))
    else $error("EEPROM address changed mid-write");
  erase_self_clear_a: assert property ($fell(busy_q) && cmd_q.kind == FWC_OP_FLASH_ERASE
                                       |-> !erase_q)
    else $error("erase enable not cleared");
  unlock_zero_a: assert property (sfr_req.rd && sfr_req.addr == `FWC_IDX_UNLOCK
                                  |=> sfr_rdata == 8'h00)
    else $error("unlock register read nonzero");

  flash_write_c: cover property (cmd_q.start && cmd_q.kind == FWC_OP_FLASH_WRITE);
  flash_erase_c: cover property (cmd_q.start && cmd_q.kind == FWC_OP_FLASH_ERASE);
  ee_write_c: cover property (cmd_q.start && cmd_q.kind == FWC_OP_EE_WRITE);
  ee_read_c: cover property (rd_q ##1 !rd_q);

endmodule // fwc_top

// >>> fwc_top_tb.sv
/*
  Self-checking bench for the nonvolatile write control block.
  Assumes the array model file and the design files are compiled first.
*/
`timescale 1ns/100ps
`include "fwc_cfg.svh"

module fwc_top_tb;
  import fwc_pkg::*;

  typedef struct {logic [7:0] v; logic [7:0] m;} fwc_note_t;
  typedef struct {fwc_op_t k; logic [15:0] a;} fwc_cmd_note_t;

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic warm_reset = 1'b0;
  fwc_sfr_req_t sfr_req;
  logic [7:0] sfr_rdata, flash_rd_data, ee_rd_data, lo, d;
  logic table_op_valid, table_op_write, ee_rd_strobe, cpu_stall, nvm_done_flag, rd_seen;
  fwc_step_t table_op_step;
  logic [21:0] table_pointer;
  fwc_cmd_t nvm_cmd;
  logic [511:0] hold_data;
  logic [9:0] ee_addr;
  logic [7:0] b [0:7];
  fwc_note_t notes[$];
  fwc_cmd_note_t cmds[$];
  fwc_note_t n;
  fwc_cmd_note_t c;
  int fails = 0;
  int samples_checked = 0;
  int starts = 0;
  int strobes = 0;
  int cycles = 0;
  integer seed;
  logic [7:0] modes [0:1] = '{8'h96, 8'hC6};
  fwc_op_t kinds [0:1] = '{FWC_OP_FLASH_ERASE, FWC_OP_CFG_WRITE};

  fwc_top uut (.core_clk(core_clk), .reset_n(reset_n), .warm_reset(warm_reset),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .table_op_valid(table_op_valid),
    .table_op_write(table_op_write), .table_op_step(table_op_step),
    .flash_rd_data(flash_rd_data), .table_pointer(table_pointer), .nvm_cmd(nvm_cmd),
    .hold_data(hold_data), .ee_rd_data(ee_rd_data), .ee_rd_strobe(ee_rd_strobe),
    .cpu_stall(cpu_stall), .nvm_done_flag(nvm_done_flag));

  fwc_array_model arrays (.core_clk(core_clk), .nvm_cmd(nvm_cmd), .hold_data(hold_data),
    .table_pointer(table_pointer), .ee_rd_strobe(ee_rd_strobe),
    .flash_rd_data(flash_rd_data), .ee_rd_data(ee_rd_data), .ee_addr(ee_addr));

  // -----------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------
  always #2 core_clk = ~core_clk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One access, then an idle cycle so no strobe is driven twice in a step.
  task automatic sfr(input logic w, input logic [3:0] a, input logic [7:0] dat);
    sfr_req <= '{wr: w, rd: !w, addr: a, wdata: dat};
    @(negedge core_clk);
    sfr_req <= '0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] v, input logic [7:0] m);
    notes.push_back('{v, m});
    sfr(1'b0, a, 8'h00);
  endtask

  task automatic tbl(input logic w);
    table_op_valid <= 1'b1;
    table_op_write <= w;
    @(negedge core_clk);
    table_op_valid <= 1'b0;
    @(negedge core_clk);
  endtask

  // Permit first, then the key pair, then start; brk slips a read in.
  task automatic go(input logic [7:0] ctl, input logic brk);
    sfr(1'b1, `FWC_IDX_CTRL, ctl & 8'hFD);
    sfr(1'b1, `FWC_IDX_UNLOCK, `FWC_UNLOCK_KEY1);
    if (brk) rd(`FWC_IDX_CTRL, 8'h04, 8'h04);
    sfr(1'b1, `FWC_IDX_UNLOCK, `FWC_UNLOCK_KEY2);
    sfr(1'b1, `FWC_IDX_CTRL, ctl);
  endtask

  task automatic wait_done;
    for (int i = 0; i < 700 && nvm_done_flag !== 1'b1; i++) @(negedge core_clk);
    check(nvm_done_flag, 1'b1, "done flag");
    check(cpu_stall, 1'b0, "stall after write");
    check(hold_data === {64{8'hFF}}, 1'b1, "holding cleared");
    rd(`FWC_IDX_CTRL, 8'h00, 8'h1A);
    rd(`FWC_IDX_FLAG4, 8'h40, 8'h40);
    sfr(1'b1, `FWC_IDX_FLAG4, 8'h00);
    rd(`FWC_IDX_FLAG4, 8'h00, 8'h40);
  endtask

  // -----------------------------------------------------------
  // Watchers
  // -----------------------------------------------------------
  // Read data is registered, so it is compared half a cycle after the read edge.
  always @(posedge core_clk)
  begin
    rd_seen <= sfr_req.rd;
    if (ee_rd_strobe === 1'b1) strobes++;
    cycles++;
    if (cycles == 12000)
    begin
      fails++;
      $display("ERROR %0t run did not finish", $time);
      end_sim();
    end
  end

  always @(negedge core_clk)
  begin
    if (rd_seen === 1'b1 && notes.size() > 0)
    begin
      n = notes.pop_front();
      check(sfr_rdata & n.m, n.v & n.m, "register read");
    end
    if (nvm_cmd.start === 1'b1)
    begin
      starts++;
      c = (cmds.size() > 0) ? cmds.pop_front() : '{FWC_OP_EE_WRITE, 16'hFFFF};
      check(nvm_cmd.kind, c.k, "command kind");
      check((c.k == FWC_OP_EE_WRITE) ? {6'h00, nvm_cmd.ee_addr} : nvm_cmd.block, c.a,
        "command address");
    end
  end

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial
  begin
    seed = 32'hDBF4;
    sfr_req = '0;
    table_op_valid = 1'b0;
    table_op_write = 1'b0;
    table_op_step = FWC_STEP_POST_INC;
    lo = $random(seed);
    d = $random(seed);
    ee_addr = {2'b11, lo};
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    check(hold_data === {64{8'hFF}}, 1'b1, "holding reset");
    rd(`FWC_IDX_CTRL, 8'h00, 8'hFF);
    rd(`FWC_IDX_UNLOCK, 8'h00, 8'hFF);
    $display("test reset done");
    // Refused starts: permit with start in one write, then a broken unlock.
    sfr(1'b1, `FWC_IDX_EE_ADDR_HI, 8'hFF);
    sfr(1'b1, `FWC_IDX_EE_ADDR_LO, lo);
    sfr(1'b1, `FWC_IDX_EE_DATA, d);
    sfr(1'b1, `FWC_IDX_UNLOCK, `FWC_UNLOCK_KEY1);
    sfr(1'b1, `FWC_IDX_UNLOCK, `FWC_UNLOCK_KEY2);
    sfr(1'b1, `FWC_IDX_CTRL, 8'h06);
    go(8'h06, 1'b1);
    check(starts, 0, "refused starts");
    $display("test refusal done");
    // EEPROM write; writes during the busy time must be ignored.
    cmds.push_back('{FWC_OP_EE_WRITE, {6'h00, 2'b11, lo}});
    go(8'h06, 1'b0);
    sfr(1'b1, `FWC_IDX_EE_DATA, ~d);
    sfr(1'b1, `FWC_IDX_CTRL, 8'h00);
    rd(`FWC_IDX_CTRL, 8'h06, 8'h06);
    wait_done();
    $display("test eeprom write done");
    // EEPROM read: refused with program space selected, then taken.
    sfr(1'b1, `FWC_IDX_CTRL, 8'h81);
    check(strobes, 0, "refused read");
    sfr(1'b1, `FWC_IDX_CTRL, 8'h01);
    check(strobes, 1, "read cycle");
    rd(`FWC_IDX_CTRL, 8'h00, 8'h01);
    rd(`FWC_IDX_EE_DATA, d, 8'hFF);
    $display("test eeprom read done");
    // Flash block: eight table writes, programme, read back.
    sfr(1'b1, `FWC_IDX_TP_UPPER, 8'h00);
    sfr(1'b1, `FWC_IDX_TP_HIGH, lo);
    sfr(1'b1, `FWC_IDX_TP_LOW, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = $random(seed);
      sfr(1'b1, `FWC_IDX_TLATCH, b[i]);
      tbl(1'b1);
      check(hold_data[8*i +: 8], b[i], "holding byte");
    end
    check(hold_data[64 +: 8], 8'hFF, "untouched holding byte");
    check(table_pointer, {6'h00, lo, 8'h08}, "pointer step");
    cmds.push_back('{FWC_OP_FLASH_WRITE, {6'h00, lo, 2'b00}});
    go(8'h84 | 8'h02, 1'b0);
    check(cpu_stall, 1'b1, "stall during write");
    wait_done();
    sfr(1'b1, `FWC_IDX_TP_LOW, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      tbl(1'b0);
      rd(`FWC_IDX_TLATCH, b[i], 8'hFF);
    end
    $display("test flash write done");
    // Row erase and configuration space.
    for (int k = 0; k < 2; k++)
    begin
      cmds.push_back('{kinds[k], {6'h00, lo, 2'b00}});
      go(modes[k], 1'b0);
      wait_done();
    end
    $display("test modes done");
    // Warm reset in mid-write leaves the abort flag.
    cmds.push_back('{FWC_OP_EE_WRITE, {6'h00, 2'b11, lo}});
    go(8'h06, 1'b0);
    repeat (10) @(negedge core_clk);
    warm_reset = 1'b1;
    @(negedge core_clk);
    warm_reset = 1'b0;
    @(negedge core_clk);
    rd(`FWC_IDX_CTRL, 8'h08, 8'h0E);
    check(starts, 5, "start count");
    $display("test abort done");
    end_sim();
  end
endmodule // fwc_top_tb
